// >>> sci_buf_pkg.sv
// constants and types shared by the serial data buffer and its rate generator
package sci_buf_pkg;

  // --------------------------------------------------------------------------
  // register byte addresses
  // --------------------------------------------------------------------------
  localparam logic [7:0] SERIAL_DATA_BUFFER_OFS = 8'h18;
  localparam logic [7:0] SERIAL_RATE_SELECT_OFS = 8'h1c;
  localparam logic [7:0] SERIAL_STATUS_ONE_OFS = 8'h20;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h24;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h28;

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int RATE_SEL_LSB = 0;
  localparam int PRESCALE_SEL_LSB = 4;
  localparam int TX_EMPTY_BIT = 7;
  localparam int RX_FULL_BIT = 5;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_TX_BIT = 1;

  // --------------------------------------------------------------------------
  // reset values and divider figures
  // --------------------------------------------------------------------------
  localparam logic [1:0] PRESCALE_SEL_RST = 2'h0;
  localparam logic [2:0] RATE_SEL_RST = 3'h0;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam logic TX_EMPTY_RST = 1'b1;
  localparam int SAMPLE_PER_BIT = 16;
  localparam int CLK_PER_SAMPLE_UNIT = 4;

  // rate setting handed to the generator
  typedef struct packed {
    logic [1:0] prescale_sel;
    logic [2:0] rate_divide_sel;
  } rate_cfg_t;

  // ticks handed back by the generator
  typedef struct packed {
    logic sample_tick;
    logic bit_tick;
  } rate_tick_t;

  // prescale divisor from the 2-bit code
  function automatic logic [3:0] prescale_divisor(input logic [1:0] code);
    case (code)
      2'h0: prescale_divisor = 4'h1;
      2'h1: prescale_divisor = 4'h3;
      2'h2: prescale_divisor = 4'h4;
      default: prescale_divisor = 4'hd;
    endcase
  endfunction : prescale_divisor

  // rate divisor minus one, two to the code
  function automatic logic [6:0] rate_limit(input logic [2:0] code);
    rate_limit = 7'((8'h01 << code) - 8'h01);
  endfunction : rate_limit

endpackage : sci_buf_pkg

// >>> sci_rate_gen.sv
// prescaler, binary rate divider and bit tick for both serial directions
`timescale 1ns/1ns
module sci_rate_gen
  import sci_buf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // setting and ticks
  input rate_cfg_t cfg,
  output rate_tick_t ticks
);

  typedef struct packed {
    logic [5:0] pre_cnt;
    logic [6:0] rate_cnt;
    logic [3:0] os_cnt;
    logic sample_tick;
    logic bit_tick;
  } gen_state_t;

  gen_state_t st_reg;
  gen_state_t st_next;
  logic [5:0] pre_top;

  assign pre_top = 6'(CLK_PER_SAMPLE_UNIT * prescale_divisor(cfg.prescale_sel) - 1);

  always_comb
  begin
    st_next = st_reg;
    st_next.sample_tick = 1'b0;
    st_next.bit_tick = 1'b0;
    // clk divided by four times the prescale divisor
    if (st_reg.pre_cnt >= pre_top)
    begin
      st_next.pre_cnt = 6'h00;
      // then divided by two to the rate code
      if (st_reg.rate_cnt >= rate_limit(cfg.rate_divide_sel))
      begin
        st_next.rate_cnt = 7'h00;
        st_next.sample_tick = 1'b1;
        st_next.os_cnt = 4'(st_reg.os_cnt + 4'h1);
        // sixteen samples make one bit, the 64 of the rate formula
        if (st_reg.os_cnt == 4'(SAMPLE_PER_BIT - 1))
        begin
          st_next.bit_tick = 1'b1;
        end
      end
      else
      begin
        st_next.rate_cnt = 7'(st_reg.rate_cnt + 7'h01);
      end
    end
    else
    begin
      st_next.pre_cnt = 6'(st_reg.pre_cnt + 6'h01);
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign ticks = {st_reg.sample_tick, st_reg.bit_tick};

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  // widest period is 4 * 13 * 128 = 6656 clocks
  logic [12:0] gap_cnt;
  logic settled;
  logic [12:0] want_gap;
  assign want_gap = 13'(CLK_PER_SAMPLE_UNIT * prescale_divisor(cfg.prescale_sel)
                        * (rate_limit(cfg.rate_divide_sel) + 1));

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gap_cnt <= 13'h0000;
      settled <= 1'b0;
    end
    else
    begin
      gap_cnt <= st_reg.sample_tick ? 13'h0001 : 13'(gap_cnt + 13'h0001);
      if (!$stable(cfg))
        settled <= 1'b0;
      else if (st_reg.sample_tick)
        settled <= 1'b1;
    end
  end

  a_sample_gap: assert property (@(posedge clk) disable iff (!rstn)
    (st_reg.sample_tick && settled && $stable(cfg)) |-> (gap_cnt == want_gap))
    else $error("sample tick spacing wrong");

  a_bit_on_sample: assert property (@(posedge clk) disable iff (!rstn)
    st_reg.bit_tick |-> st_reg.sample_tick && st_reg.os_cnt == 4'h0)
    else $error("bit tick not on sixteenth sample");

endmodule : sci_rate_gen

// >>> sci_data_buffer.sv
// serial data buffer, rate register, flags and interrupt behind an avalon slave
// ----------------------------------------------------------------------------
// Notes on behaviour
// - reading the data address returns the held received byte; not writable
// - writing the data address loads a separate transmit byte for sending
// - reset leaves both data bytes untouched
// - one rate setting times receiver and transmitter alike
// - prescale code 00,01,10,11 selects divisor 1,3,4,13
// - rate code selects divisor two to the code, 1 up to 128
// - bit rate is clock over 64, prescale divisor and rate divisor
// - reset clears the prescale code; software reads and writes it
// - reset clears the rate code; software reads and writes it
// - receive full clears on status read while set, then data read
// - transmit empty clears on status read while set, then data write
// ----------------------------------------------------------------------------
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ns
module sci_data_buffer
  import sci_buf_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // receive shift register side
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // transmit shift register side
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // shared bit timing
  output logic sample_tick,
  output logic bit_tick,
  // interrupt
  output logic irq
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [1:0] prescale_sel;
    logic [2:0] rate_divide_sel;
    logic receive_full_flag;
    logic transmit_empty_flag;
    logic rx_armed;
    logic tx_armed;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
  } ctl_state_t;

  typedef struct packed {
    logic [7:0] received_bits;
    logic [7:0] transmit_bits;
  } data_state_t;

  ctl_state_t st_reg;
  ctl_state_t st_next;
  data_state_t dat_reg;
  data_state_t dat_next;

  logic req;
  logic rd_take;
  logic wr_take;
  logic tx_load;
  logic [7:0] addr8;
  rate_cfg_t cfg;
  rate_tick_t ticks;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // --------------------------------------------------------------------------
  // bus handshake
  // --------------------------------------------------------------------------
  assign addr8 = 8'(address);
  assign req = read || write;
  assign waitrequest = req && !st_reg.ack;
  assign rd_take = read && st_reg.ack;
  assign wr_take = write && st_reg.ack;
  assign tx_load = tx_valid && tx_ready;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    dat_next = dat_reg;
    st_next.ack = req && !st_reg.ack;

    // read data captured in the wait cycle
    if (req && !st_reg.ack)
    begin
      st_next.rdata = 32'h0000_0000;
      if (hit(addr8, SERIAL_DATA_BUFFER_OFS))
        st_next.rdata[7:0] = dat_reg.received_bits;
      else if (hit(addr8, SERIAL_RATE_SELECT_OFS))
      begin
        st_next.rdata[PRESCALE_SEL_LSB +: 2] = st_reg.prescale_sel;
        st_next.rdata[RATE_SEL_LSB +: 3] = st_reg.rate_divide_sel;
      end
      else if (hit(addr8, SERIAL_STATUS_ONE_OFS))
      begin
        st_next.rdata[TX_EMPTY_BIT] = st_reg.transmit_empty_flag;
        st_next.rdata[RX_FULL_BIT] = st_reg.receive_full_flag;
      end
      else if (hit(addr8, IRQ_STATUS_OFS))
        st_next.rdata[1:0] = st_reg.irq_status;
      else if (hit(addr8, IRQ_MASK_OFS))
        st_next.rdata[1:0] = st_reg.irq_mask;
    end

    // register writes at acceptance
    if (wr_take && byteenable[0])
    begin
      if (hit(addr8, SERIAL_DATA_BUFFER_OFS))
        dat_next.transmit_bits = writedata[7:0];
      else if (hit(addr8, SERIAL_RATE_SELECT_OFS))
      begin
        st_next.prescale_sel = writedata[PRESCALE_SEL_LSB +: 2];
        st_next.rate_divide_sel = writedata[RATE_SEL_LSB +: 3];
      end
      else if (hit(addr8, IRQ_MASK_OFS))
        st_next.irq_mask = writedata[1:0];
    end

    // flag clearing sequences: status read while set arms, data access clears
    if (rd_take && hit(addr8, SERIAL_STATUS_ONE_OFS))
    begin
      st_next.rx_armed = st_reg.rdata[RX_FULL_BIT];
      st_next.tx_armed = st_reg.rdata[TX_EMPTY_BIT];
    end
    if (rd_take && hit(addr8, SERIAL_DATA_BUFFER_OFS) && st_reg.rx_armed)
    begin
      st_next.receive_full_flag = 1'b0;
      st_next.rx_armed = 1'b0;
    end
    if (wr_take && byteenable[0] && hit(addr8, SERIAL_DATA_BUFFER_OFS) && st_reg.tx_armed)
    begin
      st_next.transmit_empty_flag = 1'b0;
      st_next.tx_armed = 1'b0;
    end

    // interrupt status, write one to clear
    if (wr_take && byteenable[0] && hit(addr8, IRQ_STATUS_OFS))
      st_next.irq_status = st_reg.irq_status & ~writedata[1:0];

    // shift register events; setting wins over clearing
    if (rx_valid)
    begin
      dat_next.received_bits = rx_data;
      st_next.receive_full_flag = 1'b1;
      st_next.irq_status[IRQ_RX_BIT] = 1'b1;
    end
    if (tx_load)
    begin
      st_next.transmit_empty_flag = 1'b1;
      st_next.irq_status[IRQ_TX_BIT] = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg.ack <= 1'b0;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.prescale_sel <= PRESCALE_SEL_RST;
      st_reg.rate_divide_sel <= RATE_SEL_RST;
      st_reg.receive_full_flag <= 1'b0;
      st_reg.transmit_empty_flag <= TX_EMPTY_RST;
      st_reg.rx_armed <= 1'b0;
      st_reg.tx_armed <= 1'b0;
      st_reg.irq_status <= 2'h0;
      st_reg.irq_mask <= IRQ_MASK_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // data bytes keep their contents through reset
  always_ff @(posedge clk)
  begin
    dat_reg <= dat_next;
  end

  // --------------------------------------------------------------------------
  // shared rate generator
  // --------------------------------------------------------------------------
  assign cfg = {st_reg.prescale_sel, st_reg.rate_divide_sel};

  sci_rate_gen u_rate_gen (
    .clk(clk),
    .rstn(rstn),
    .cfg(cfg),
    .ticks(ticks)
  );

  // one tick pair serves both directions
  assign sample_tick = ticks.sample_tick;
  assign bit_tick = ticks.bit_tick;

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign readdata = st_reg.rdata;
  assign tx_valid = !st_reg.transmit_empty_flag;
  assign tx_data = dat_reg.transmit_bits;
  assign irq = |(st_reg.irq_status & st_reg.irq_mask);

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_wait_bounded: assert property (@(posedge clk) disable iff (!rstn)
    (req && !st_reg.ack) |=> !waitrequest || !req)
    else $error("waitrequest held too long");

  a_read_rx_byte: assert property (@(posedge clk) disable iff (!rstn)
    (rd_take && hit(addr8, SERIAL_DATA_BUFFER_OFS))
      |-> readdata == {24'h000000, $past(dat_reg.received_bits)})
    else $error("data read did not return received byte");

  a_write_tx_byte: assert property (@(posedge clk) disable iff (!rstn)
    (wr_take && byteenable[0] && hit(addr8, SERIAL_DATA_BUFFER_OFS))
      |=> tx_data == $past(writedata[7:0]))
    else $error("data write did not load transmit byte");

  a_rate_write: assert property (@(posedge clk) disable iff (!rstn)
    (wr_take && byteenable[0] && hit(addr8, SERIAL_RATE_SELECT_OFS))
      |=> cfg.rate_divide_sel == $past(writedata[2:0])
          && cfg.prescale_sel == $past(writedata[5:4]))
    else $error("rate select write lost");

  a_rx_full_set: assert property (@(posedge clk) disable iff (!rstn)
    rx_valid |=> st_reg.receive_full_flag && st_reg.irq_status[IRQ_RX_BIT])
    else $error("receive full not set on arrival");

  a_rx_full_clear: assert property (@(posedge clk) disable iff (!rstn)
    (st_reg.rx_armed && rd_take && hit(addr8, SERIAL_DATA_BUFFER_OFS) && !rx_valid)
      |=> !st_reg.receive_full_flag)
    else $error("receive full not cleared by sequence");

  a_tx_empty_clear: assert property (@(posedge clk) disable iff (!rstn)
    (st_reg.tx_armed && wr_take && byteenable[0]
      && hit(addr8, SERIAL_DATA_BUFFER_OFS) && !tx_load)
      |=> !st_reg.transmit_empty_flag ##0 tx_valid)
    else $error("transmit empty not cleared by sequence");

  a_no_clear_unarmed: assert property (@(posedge clk) disable iff (!rstn)
    (!st_reg.rx_armed && st_reg.receive_full_flag) |=> st_reg.receive_full_flag)
    else $error("receive full cleared without status read");

  a_irq_on_rx: assert property (@(posedge clk) disable iff (!rstn)
    (rx_valid && st_reg.irq_mask[IRQ_RX_BIT]
      && !(wr_take && hit(addr8, IRQ_MASK_OFS))) |=> irq)
    else $error("unmasked receive event gave no interrupt");

  // received byte is unknown until a first byte has arrived
  logic rx_seen;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_seen <= 1'b0;
    end
    else if (rx_valid)
    begin
      rx_seen <= 1'b1;
    end
  end

  // receive byte and register reads
  a_rx_kept: assert property (@(posedge clk) disable iff (!rstn)
    (rx_seen && !rx_valid) |=> dat_reg.received_bits == $past(dat_reg.received_bits))
    else $error("received byte changed without arrival");

  a_rx_byte_store: assert property (@(posedge clk) disable iff (!rstn)
    rx_valid |=> dat_reg.received_bits == $past(rx_data))
    else $error("arriving byte not stored");

  a_status_read: assert property (@(posedge clk) disable iff (!rstn)
    (rd_take && hit(addr8, SERIAL_STATUS_ONE_OFS))
      |-> readdata[RX_FULL_BIT] == $past(st_reg.receive_full_flag)
          && readdata[TX_EMPTY_BIT] == $past(st_reg.transmit_empty_flag))
    else $error("status read gave wrong flags");

  a_rate_read: assert property (@(posedge clk) disable iff (!rstn)
    (rd_take && hit(addr8, SERIAL_RATE_SELECT_OFS))
      |-> readdata[PRESCALE_SEL_LSB +: 2] == $past(st_reg.prescale_sel)
          && readdata[RATE_SEL_LSB +: 3] == $past(st_reg.rate_divide_sel))
    else $error("rate select read gave wrong code");

  a_upper_zero: assert property (@(posedge clk) disable iff (!rstn)
    rd_take |-> readdata[31:8] == 24'h000000)
    else $error("unused read bits not zero");

  a_rdata_hold: assert property (@(posedge clk) disable iff (!rstn)
    !req |=> $stable(readdata))
    else $error("read data changed while idle");

  // transmit side and interrupt bits
  a_tx_empty_set: assert property (@(posedge clk) disable iff (!rstn)
    tx_load |=> st_reg.transmit_empty_flag && !tx_valid && st_reg.irq_status[IRQ_TX_BIT])
    else $error("taken byte did not set transmit empty");

  a_tx_pending: assert property (@(posedge clk) disable iff (!rstn)
    (tx_valid && !tx_ready) |=> tx_valid)
    else $error("pending transmit byte dropped");

  a_no_tx_unarmed: assert property (@(posedge clk) disable iff (!rstn)
    (!st_reg.tx_armed && st_reg.transmit_empty_flag) |=> st_reg.transmit_empty_flag)
    else $error("transmit empty cleared without status read");

  a_mask_write: assert property (@(posedge clk) disable iff (!rstn)
    (wr_take && byteenable[0] && hit(addr8, IRQ_MASK_OFS))
      |=> st_reg.irq_mask == $past(writedata[1:0]))
    else $error("interrupt mask write lost");

  a_irq_clear: assert property (@(posedge clk) disable iff (!rstn)
    (wr_take && byteenable[0] && hit(addr8, IRQ_STATUS_OFS) && writedata[IRQ_RX_BIT]
      && !rx_valid) |=> !st_reg.irq_status[IRQ_RX_BIT])
    else $error("receive interrupt bit not cleared");

endmodule : sci_data_buffer

// >>> sci_link_model.sv
// far-side model of the receive and transmit shift registers
`timescale 1ns/1ns
module sci_link_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bench commands
  input wire logic send,
  input wire logic [7:0] send_byte,
  input wire logic [3:0] stall,
  // receive shift register side
  output logic rx_valid,
  output logic [7:0] rx_data,
  // transmit shift register side
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // bytes taken so far
  output logic [7:0] taken_byte,
  output logic [7:0] taken_count
);
  logic [3:0] wait_reg;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      tx_ready <= 1'b0;
      taken_byte <= 8'h00;
      taken_count <= 8'h00;
      wait_reg <= 4'h0;
    end
    else
    begin
      rx_valid <= send;
      // data is junk outside the valid pulse
      rx_data <= send ? send_byte : ~rx_data;
      if (tx_valid && tx_ready)
      begin
        taken_byte <= tx_data;
        taken_count <= taken_count + 8'h01;
        tx_ready <= 1'b0;
        wait_reg <= 4'h0;
      end
      else if (tx_valid && wait_reg >= stall)
        tx_ready <= 1'b1;
      else if (tx_valid)
        wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule : sci_link_model

// >>> sci_data_buffer_tb.sv
// self-checking bench for the serial data buffer and rate generator
`timescale 1ns/1ns
module sci_data_buffer_tb;
  import sci_buf_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic rx_valid, tx_valid, tx_ready, sample_tick, bit_tick, irq;
  logic [7:0] rx_data, tx_data, taken_byte, taken_count;
  logic send = 1'b0;
  logic [7:0] send_byte = 8'h00;
  logic [3:0] stall = 4'h3;
  logic [31:0] rd, gap;
  int fail_count = 0;
  int checks = 0;
  int pd [4] = '{1, 3, 4, 13};

  always #50 clk = ~clk;

  sci_data_buffer dut_u (.clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .sample_tick(sample_tick), .bit_tick(bit_tick), .irq(irq));

  sci_link_model link_u (.clk(clk), .rstn(rstn), .send(send), .send_byte(send_byte),
    .stall(stall), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .taken_byte(taken_byte),
    .taken_count(taken_count));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= wd;
    do
    begin
      @(posedge clk);
    end
    while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask : rd_chk

  // edges from one tick to the next
  task automatic tick_gap(input logic use_bit, output logic [31:0] n);
    n = 0;
    repeat (2)
    begin
      do
      begin
        @(posedge clk);
        n++;
      end
      while ((use_bit ? bit_tick : sample_tick) !== 1'b1 && n < 30000);
      n = 0;
    end
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((use_bit ? bit_tick : sample_tick) !== 1'b1 && n < 30000);
  endtask : tick_gap

  task automatic reset_pulse();
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask : reset_pulse

  task automatic complete_run();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (90000) @(posedge clk);
    fail_count++;
    complete_run();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial
  begin
    reset_pulse();
    // data write without arming is held back
    bus(SERIAL_DATA_BUFFER_OFS, 1'b1, 32'h55);
    repeat (4) @(posedge clk);
    check({31'h0, tx_valid}, 32'h0);
    rd_chk(SERIAL_RATE_SELECT_OFS, 32'h0);
    rd_chk(SERIAL_STATUS_ONE_OFS, 32'h80);
    rd_chk(IRQ_MASK_OFS, 32'h0);
    rd_chk(8'h40, 32'h0);
    // every prescale and rate code
    for (int i = 0; i < 8; i++)
    begin
      bus(SERIAL_RATE_SELECT_OFS, 1'b1, {26'h0, i[1:0], 1'b0, i[2:0]});
      rd_chk(SERIAL_RATE_SELECT_OFS, {26'h0, i[1:0], 1'b0, i[2:0]});
      tick_gap(1'b0, gap);
      check(gap, 32'(4 * pd[i % 4] * (1 << i)));
      if (i == 1)
      begin
        tick_gap(1'b1, gap);
        check(gap, 32'(64 * 3 * 2));
      end
    end
    // received byte, flags and interrupt
    send_byte <= 8'ha5;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rd_chk(IRQ_STATUS_OFS, 32'h1);
    bus(IRQ_MASK_OFS, 1'b1, 32'h1);
    check({31'h0, irq}, 32'h1);
    bus(IRQ_STATUS_OFS, 1'b1, 32'h1);
    check({31'h0, irq}, 32'h0);
    rd_chk(SERIAL_STATUS_ONE_OFS, 32'ha0);
    rd_chk(SERIAL_DATA_BUFFER_OFS, 32'ha5);
    rd_chk(SERIAL_STATUS_ONE_OFS, 32'h80);
    // armed write goes out, far side stalls first
    bus(SERIAL_DATA_BUFFER_OFS, 1'b1, 32'h3c);
    check({24'h0, tx_data}, 32'h3c);
    check({31'h0, tx_valid}, 32'h1);
    rd_chk(SERIAL_DATA_BUFFER_OFS, 32'ha5);
    for (int n = 0; n < 40 && taken_count !== 8'h01; n++)
      @(posedge clk);
    check({24'h0, taken_byte}, 32'h3c);
    @(posedge clk);
    check({31'h0, tx_valid}, 32'h0);
    rd_chk(IRQ_STATUS_OFS, 32'h2);
    // reset in mid-run keeps the byte
    reset_pulse();
    rd_chk(SERIAL_DATA_BUFFER_OFS, 32'ha5);
    rd_chk(SERIAL_RATE_SELECT_OFS, 32'h0);
    tick_gap(1'b0, gap);
    check(gap, 32'h4);
    // write with byte lane 0 off leaves the rate code alone
    byteenable <= 4'he;
    bus(SERIAL_RATE_SELECT_OFS, 1'b1, 32'h37);
    byteenable <= 4'hf;
    rd_chk(SERIAL_RATE_SELECT_OFS, 32'h0);
    // data read without status read leaves receive full set
    send_byte <= 8'h5a;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(SERIAL_DATA_BUFFER_OFS, 32'h5a);
    rd_chk(SERIAL_STATUS_ONE_OFS, 32'ha0);
    rd_chk(SERIAL_DATA_BUFFER_OFS, 32'h5a);
    rd_chk(SERIAL_STATUS_ONE_OFS, 32'h80);
    complete_run();
  end
endmodule : sci_data_buffer_tb
